// ===== hdl/imasa_core.sv
// Purpose: two-wire bus master ack, stop, start and arbitration control
// Assumes: APB slave, open-drain lines with active-low enables
// Notes: one APB wait state on every access
// How it works
// - ack request pulls clock low, presents ack value
// - ack waits period, releases clock, waits, ends
// - buffer write during ack sets clash flag
// - stop drives data low, times, releases clock
// - data released later; stop seen sets flag
// - period after stop: clear request, flag event
// - buffer write during stop is discarded, flagged
// - enabled events raise the interrupt output
// - reset or disable aborts all activity
// - start and stop flags cleared when disabled
// - bus free after stop or idle; stop signals
// - released one read as zero is collision
// - arbitration checked in bytes, start, ack
// - transmit collision clears full, releases lines
// - sequence collision aborts and clears its request
// - after collision, bus stop sets event flag
// - new write restarts byte at first bit
// - start with a low line is a collision
// - start counts; low clock with high data collides
// - data low early restarts timer, drives data
// - else data low, recount, then clock low
// - timer reloads each half period of clock
`timescale 1ns/1ps
`default_nettype none
module imasa_core
  import imasa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IMASA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  output logic event_irq
);
  imasa_link_if lnk ();
  imasa_state_e state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic event_irq_r;
  logic enable_r;
  logic start_req_r;
  logic stop_request_r;
  logic ack_sequence_request_r;
  logic ack_value_bit_r;
  logic [7:0] bit_timer_reload_r;
  logic [7:0] shift_buffer_r;
  logic buffer_full_flag_r;
  logic ack_stat_r;
  logic [3:0] bit_idx_r;
  logic tmr_run_r;
  logic tmr_load_r;
  logic start_seen_r;
  logic stop_seen_r;
  logic serial_event_flag_r;
  logic bus_clash_flag_r;
  logic write_clash_flag_r;
  logic ie_sev_r;
  logic ie_bcl_r;
  logic scl_d_r;
  logic sda_d_r;
  logic set_sev_r;
  logic set_bcl_r;
  logic wr_cmt;
  logic wr_ctrl;
  logic wr_buf;
  logic buf_ok;
  logic mapped;
  logic clash;
  logic bus_start;
  logic bus_stop;
  logic in_stop;
  logic [31:0] rd_val;

  imasa_line_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .lnk(lnk)
  );

  imasa_bit_timer u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk)
  );

  assign lnk.tmr_run = tmr_run_r;
  assign lnk.tmr_load = tmr_load_r;
  assign lnk.tmr_reload = bit_timer_reload_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;
  assign event_irq = event_irq_r;

  // apb decode
  assign mapped = (paddr == IMASA_OFF_CTRL) || (paddr == IMASA_OFF_STAT) || (paddr == IMASA_OFF_FLAG) ||
                  (paddr == IMASA_OFF_IEN) || (paddr == IMASA_OFF_RELOAD) || (paddr == IMASA_OFF_SHIFT);
  assign wr_cmt = psel && penable && pready_r && pwrite && mapped;
  assign wr_ctrl = wr_cmt && (paddr == IMASA_OFF_CTRL);
  assign wr_buf = wr_cmt && (paddr == IMASA_OFF_SHIFT);
  assign buf_ok = wr_buf && (state_r == IMASA_IDLE) && !buffer_full_flag_r && enable_r;
  assign in_stop = (state_r == IMASA_STOP_A) || (state_r == IMASA_STOP_B) || (state_r == IMASA_STOP_C) ||
                   (state_r == IMASA_STOP_D) || (state_r == IMASA_STOP_E);

  // line edges seen while clock is high
  assign bus_start = scl_d_r && lnk.scl_s && sda_d_r && !lnk.sda_s;
  assign bus_stop = scl_d_r && lnk.scl_s && !sda_d_r && lnk.sda_s;

  // arbitration loss in every phase that can lose it
  always_comb begin
    clash = 1'b0;
    case (state_r)
      IMASA_IDLE: clash = start_req_r && (!lnk.sda_s || !lnk.scl_s);
      IMASA_START_A: clash = !lnk.scl_s && lnk.sda_s;
      IMASA_TX_HIGH: clash = sda_oe_n_r && !lnk.sda_s && (bit_idx_r != IMASA_ACK_BIT);
      IMASA_ACK_HIGH: clash = sda_oe_n_r && !lnk.sda_s;
      IMASA_STOP_D: clash = !lnk.scl_s || (lnk.tmr_tout && !lnk.sda_s);
      default: clash = 1'b0;
    endcase
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      IMASA_OFF_CTRL: begin
        rd_val[IMASA_C_EN] = enable_r;
        rd_val[IMASA_C_START] = start_req_r;
        rd_val[IMASA_C_STOP] = stop_request_r;
        rd_val[IMASA_C_ACK] = ack_sequence_request_r;
        rd_val[IMASA_C_ACKVAL] = ack_value_bit_r;
      end
      IMASA_OFF_STAT: begin
        rd_val[IMASA_S_START] = start_seen_r;
        rd_val[IMASA_S_STOP] = stop_seen_r;
        rd_val[IMASA_S_BF] = buffer_full_flag_r;
        rd_val[IMASA_S_ACKSTAT] = ack_stat_r;
        rd_val[IMASA_S_BUSY] = (state_r != IMASA_IDLE);
        rd_val[IMASA_S_FREE] = stop_seen_r || !start_seen_r;
      end
      IMASA_OFF_FLAG: begin
        rd_val[IMASA_F_SEV] = serial_event_flag_r;
        rd_val[IMASA_F_BCL] = bus_clash_flag_r;
        rd_val[IMASA_F_WRITE_CLASH_FLAG] = write_clash_flag_r;
      end
      IMASA_OFF_IEN: begin
        rd_val[IMASA_F_SEV] = ie_sev_r;
        rd_val[IMASA_F_BCL] = ie_bcl_r;
      end
      IMASA_OFF_RELOAD: rd_val[7:0] = bit_timer_reload_r;
      IMASA_OFF_SHIFT: rd_val[7:0] = shift_buffer_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // apb slave: one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_timer_reload_r <= IMASA_RELOAD_RST;
      ie_sev_r <= 1'b0;
      ie_bcl_r <= 1'b0;
      ack_value_bit_r <= 1'b0;
      enable_r <= 1'b0;
    end else begin
      if (wr_cmt && paddr == IMASA_OFF_RELOAD) begin
        bit_timer_reload_r <= pwdata[7:0];
      end
      if (wr_cmt && paddr == IMASA_OFF_IEN) begin
        ie_sev_r <= pwdata[IMASA_F_SEV];
        ie_bcl_r <= pwdata[IMASA_F_BCL];
      end
      if (wr_ctrl) begin
        ack_value_bit_r <= pwdata[IMASA_C_ACKVAL];
        enable_r <= pwdata[IMASA_C_EN];
      end
    end
  end

  // sequencer, line drivers, requests and shift buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= IMASA_IDLE;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      start_req_r <= 1'b0;
      stop_request_r <= 1'b0;
      ack_sequence_request_r <= 1'b0;
      shift_buffer_r <= 8'h00;
      buffer_full_flag_r <= 1'b0;
      ack_stat_r <= 1'b0;
      bit_idx_r <= 4'h0;
      tmr_run_r <= 1'b0;
      tmr_load_r <= 1'b0;
      set_sev_r <= 1'b0;
      set_bcl_r <= 1'b0;
    end else begin
      tmr_load_r <= 1'b0;
      set_sev_r <= 1'b0;
      set_bcl_r <= 1'b0;
      if (!enable_r) begin
        state_r <= IMASA_IDLE;
        scl_oe_n_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
        start_req_r <= 1'b0;
        stop_request_r <= 1'b0;
        ack_sequence_request_r <= 1'b0;
        buffer_full_flag_r <= 1'b0;
        tmr_run_r <= 1'b0;
      end else if (clash) begin
        state_r <= IMASA_IDLE;
        scl_oe_n_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
        start_req_r <= 1'b0;
        stop_request_r <= 1'b0;
        ack_sequence_request_r <= 1'b0;
        buffer_full_flag_r <= 1'b0;
        tmr_run_r <= 1'b0;
        set_bcl_r <= 1'b1;
      end else begin
        if (wr_ctrl && state_r == IMASA_IDLE) begin
          start_req_r <= pwdata[IMASA_C_START];
          stop_request_r <= pwdata[IMASA_C_STOP];
          ack_sequence_request_r <= pwdata[IMASA_C_ACK];
        end
        case (state_r)
          IMASA_IDLE: begin
            tmr_run_r <= 1'b0;
            if (start_req_r) begin
              state_r <= IMASA_START_A;
              tmr_run_r <= 1'b1;
              tmr_load_r <= 1'b1;
            end else if (stop_request_r) begin
              sda_oe_n_r <= 1'b0;
              tmr_run_r <= 1'b1;
              state_r <= IMASA_STOP_A;
            end else if (ack_sequence_request_r) begin
              scl_oe_n_r <= 1'b0;
              sda_oe_n_r <= ack_value_bit_r;
              tmr_run_r <= 1'b1;
              tmr_load_r <= 1'b1;
              state_r <= IMASA_ACK_LOW;
            end else if (buf_ok) begin
              shift_buffer_r <= pwdata[7:0];
              buffer_full_flag_r <= 1'b1;
              bit_idx_r <= 4'h0;
              scl_oe_n_r <= 1'b0;
              sda_oe_n_r <= pwdata[7];
              tmr_run_r <= 1'b1;
              tmr_load_r <= 1'b1;
              state_r <= IMASA_TX_LOW;
            end
          end
          IMASA_START_A: begin
            if (!lnk.sda_s) begin
              sda_oe_n_r <= 1'b0;
              tmr_load_r <= 1'b1;
              state_r <= IMASA_START_B;
            end else if (lnk.tmr_tout) begin
              sda_oe_n_r <= 1'b0;
              state_r <= IMASA_START_B;
            end
          end
          IMASA_START_B: begin
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b0;
              start_req_r <= 1'b0;
              set_sev_r <= 1'b1;
              state_r <= IMASA_IDLE;
            end
          end
          IMASA_TX_LOW: begin
            // data moves a cycle after the clock falls here; from idle the first bit is set with the clock
            sda_oe_n_r <= (bit_idx_r == IMASA_ACK_BIT) || shift_buffer_r[7];
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b1;
              state_r <= IMASA_TX_WAITH;
            end
          end
          IMASA_TX_WAITH: begin
            tmr_load_r <= 1'b1;
            if (lnk.scl_s) begin
              state_r <= IMASA_TX_HIGH;
            end
          end
          IMASA_TX_HIGH: begin
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b0;
              if (bit_idx_r == IMASA_ACK_BIT) begin
                ack_stat_r <= lnk.sda_s;
                set_sev_r <= 1'b1;
                state_r <= IMASA_IDLE;
              end else begin
                bit_idx_r <= bit_idx_r + 4'h1;
                shift_buffer_r <= {shift_buffer_r[6:0], 1'b0};
                if (bit_idx_r == IMASA_LAST_DATA_BIT) begin
                  buffer_full_flag_r <= 1'b0;
                end
                state_r <= IMASA_TX_LOW;
              end
            end
          end
          IMASA_ACK_LOW: begin
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b1;
              state_r <= IMASA_ACK_WAITH;
            end
          end
          IMASA_ACK_WAITH: begin
            tmr_load_r <= 1'b1;
            if (lnk.scl_s) begin
              state_r <= IMASA_ACK_HIGH;
            end
          end
          IMASA_ACK_HIGH: begin
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b0;
              ack_sequence_request_r <= 1'b0;
              tmr_run_r <= 1'b0;
              set_sev_r <= 1'b1;
              state_r <= IMASA_IDLE;
            end
          end
          IMASA_STOP_A: begin
            tmr_load_r <= 1'b1;
            if (!lnk.sda_s) begin
              state_r <= IMASA_STOP_B;
            end
          end
          IMASA_STOP_B: begin
            if (lnk.tmr_tout) begin
              scl_oe_n_r <= 1'b1;
              state_r <= IMASA_STOP_C;
            end
          end
          IMASA_STOP_C: begin
            if (lnk.tmr_tout) begin
              sda_oe_n_r <= 1'b1;
              state_r <= IMASA_STOP_D;
            end
          end
          IMASA_STOP_D: begin
            if (lnk.sda_s && lnk.scl_s) begin
              tmr_load_r <= 1'b1;
              state_r <= IMASA_STOP_E;
            end
          end
          IMASA_STOP_E: begin
            if (lnk.tmr_tout) begin
              stop_request_r <= 1'b0;
              set_sev_r <= 1'b1;
              tmr_run_r <= 1'b0;
              state_r <= IMASA_IDLE;
            end
          end
          default: state_r <= IMASA_IDLE;
        endcase
      end
    end
  end

  // start and stop detect flags watch the bus while enabled, held clear when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      scl_d_r <= lnk.scl_s;
      sda_d_r <= lnk.sda_s;
      if (!enable_r) begin
        start_seen_r <= 1'b0;
        stop_seen_r <= 1'b0;
      end else if (bus_start) begin
        start_seen_r <= 1'b1;
        stop_seen_r <= 1'b0;
      end else if (bus_stop) begin
        stop_seen_r <= 1'b1;
        start_seen_r <= 1'b0;
      end
    end
  end

  // sticky flags: hardware set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_event_flag_r <= 1'b0;
      bus_clash_flag_r <= 1'b0;
      write_clash_flag_r <= 1'b0;
      event_irq_r <= 1'b0;
    end else begin
      if (set_sev_r || (bus_stop && enable_r && !in_stop)) begin
        serial_event_flag_r <= 1'b1;
      end else if (wr_cmt && paddr == IMASA_OFF_FLAG && pwdata[IMASA_F_SEV]) begin
        serial_event_flag_r <= 1'b0;
      end
      if (set_bcl_r) begin
        bus_clash_flag_r <= 1'b1;
      end else if (wr_cmt && paddr == IMASA_OFF_FLAG && pwdata[IMASA_F_BCL]) begin
        bus_clash_flag_r <= 1'b0;
      end
      if (wr_buf && !buf_ok) begin
        write_clash_flag_r <= 1'b1;
      end else if (wr_cmt && paddr == IMASA_OFF_FLAG && pwdata[IMASA_F_WRITE_CLASH_FLAG]) begin
        write_clash_flag_r <= 1'b0;
      end
      event_irq_r <= (serial_event_flag_r && ie_sev_r) || (bus_clash_flag_r && ie_bcl_r);
    end
  end
endmodule
`default_nettype wire

// ===== hdl/imasa_pkg.sv
// Purpose: shared constants for the bus master closing and arbitration block
// Assumes: APB data 32 bits, byte addresses
// Notes: field positions index the register words
package imasa_pkg;
  localparam int unsigned IMASA_ADDR_W = 8;
  localparam logic [7:0] IMASA_OFF_CTRL = 8'h00;
  localparam logic [7:0] IMASA_OFF_STAT = 8'h04;
  localparam logic [7:0] IMASA_OFF_FLAG = 8'h08;
  localparam logic [7:0] IMASA_OFF_IEN = 8'h0C;
  localparam logic [7:0] IMASA_OFF_RELOAD = 8'h10;
  localparam logic [7:0] IMASA_OFF_SHIFT = 8'h14;
  // bus_control_two fields
  localparam int unsigned IMASA_C_EN = 0;
  localparam int unsigned IMASA_C_START = 1;
  localparam int unsigned IMASA_C_STOP = 2;
  localparam int unsigned IMASA_C_ACK = 3;
  localparam int unsigned IMASA_C_ACKVAL = 4;
  // bus_status_reg fields
  localparam int unsigned IMASA_S_START = 0;
  localparam int unsigned IMASA_S_STOP = 1;
  localparam int unsigned IMASA_S_BF = 2;
  localparam int unsigned IMASA_S_ACKSTAT = 3;
  localparam int unsigned IMASA_S_BUSY = 4;
  localparam int unsigned IMASA_S_FREE = 5;
  // flag and enable fields
  localparam int unsigned IMASA_F_SEV = 0;
  localparam int unsigned IMASA_F_BCL = 1;
  localparam int unsigned IMASA_F_WRITE_CLASH_FLAG = 2;
  localparam logic [7:0] IMASA_RELOAD_RST = 8'h13;
  localparam int unsigned IMASA_SYNC_STAGES = 3;
  localparam logic [3:0] IMASA_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] IMASA_ACK_BIT = 4'h8;
  typedef enum logic [3:0] {
    IMASA_IDLE, IMASA_START_A, IMASA_START_B, IMASA_TX_LOW, IMASA_TX_WAITH, IMASA_TX_HIGH,
    IMASA_ACK_LOW, IMASA_ACK_WAITH, IMASA_ACK_HIGH, IMASA_STOP_A, IMASA_STOP_B, IMASA_STOP_C,
    IMASA_STOP_D, IMASA_STOP_E
  } imasa_state_e;
endpackage

// ===== hdl/imasa_link_if.sv
// Purpose: carrier between the core, its bit timer and its line synchroniser
// Assumes: single clock domain
// Notes: scl_s and sda_s are filtered line levels
`timescale 1ns/1ps
`default_nettype none
interface imasa_link_if;
  logic scl_s;
  logic sda_s;
  logic tmr_run;
  logic tmr_load;
  logic [7:0] tmr_reload;
  logic tmr_tout;
  modport core (input scl_s, input sda_s, input tmr_tout, output tmr_run, output tmr_load, output tmr_reload);
  modport tmr (input tmr_run, input tmr_load, input tmr_reload, output tmr_tout);
  modport syn (output scl_s, output sda_s);
endinterface
`default_nettype wire

// ===== hdl/imasa_bit_timer.sv
// Purpose: bit_timer down-counter giving one half bus clock period per rollover
// Assumes: reload value 3 or more
// Notes: one rollover lasts 2*(reload+1) clocks
`timescale 1ns/1ps
`default_nettype none
module imasa_bit_timer
  import imasa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  imasa_link_if.tmr lnk
);
  logic [8:0] cnt_r;
  logic tout_r;
  assign lnk.tmr_tout = tout_r;
  // reloads at every half bus clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 9'h000;
      tout_r <= 1'b0;
    end else if (!lnk.tmr_run || lnk.tmr_load) begin
      cnt_r <= {lnk.tmr_reload, 1'b1};
      tout_r <= 1'b0;
    end else if (cnt_r == 9'h000) begin
      cnt_r <= {lnk.tmr_reload, 1'b1};
      tout_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 9'h001;
      tout_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/imasa_line_sync.sv
// Purpose: three-stage synchroniser for the clock and data lines
// Assumes: pins are asynchronous to pclk
// Notes: a level counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module imasa_line_sync
  import imasa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_i,
  input wire logic sda_i,
  imasa_link_if.syn lnk
);
  logic [1:0] raw;
  logic [1:0] lvl_r;
  assign raw = {scl_i, sda_i};
  assign lnk.scl_s = lvl_r[1];
  assign lnk.sda_s = lvl_r[0];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [IMASA_SYNC_STAGES-1:0] st_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_r <= '1;
          lvl_r[g] <= 1'b1;
        end else begin
          st_r <= {st_r[IMASA_SYNC_STAGES-2:0], raw[g]};
          if (st_r[1] == st_r[2]) begin
            lvl_r[g] <= st_r[2];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== test/imasa_core_sva.sv
// Purpose: port assertions for imasa_core
// Assumes: one clock, presetn active low
// Notes: shadows of ctrl and ien writes
`timescale 1ns/1ps
`default_nettype none
module imasa_core_sva
  import imasa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IMASA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic event_irq
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr, ack_w, stop_w, ackv_r, en_r;
  logic [1:0] ien_r;
  assign wr = psel && penable && pready && pwrite;
  assign ack_w = wr && paddr == IMASA_OFF_CTRL && pwdata[IMASA_C_ACK] && pwdata[IMASA_C_EN] && en_r;
  assign stop_w = wr && paddr == IMASA_OFF_CTRL && pwdata[IMASA_C_STOP] && pwdata[IMASA_C_EN] && en_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ackv_r <= 1'b0;
      en_r <= 1'b0;
      ien_r <= 2'b00;
    end else if (wr && paddr == IMASA_OFF_CTRL) begin
      ackv_r <= pwdata[IMASA_C_ACKVAL];
      en_r <= pwdata[IMASA_C_EN];
    end else if (wr && paddr == IMASA_OFF_IEN) begin
      ien_r <= pwdata[1:0];
    end
  end
  reset_idle_a: assert property ($rose(presetn) |-> scl_oe_n && sda_oe_n && !event_irq)
    else $error("lines or irq active after reset");
  apb_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a single access pulse");
  err_map_a: assert property (pslverr |-> pready && (paddr > IMASA_OFF_SHIFT || paddr[1:0] != 2'b00))
    else $error("pslverr on a mapped address");
  ack_drive_a: assert property (ack_w |-> ##[1:4] (!scl_oe_n && sda_oe_n == ackv_r))
    else $error("ack request did not drive the lines");
  ack_hold_a: assert property (ack_w |-> ##3 (!scl_oe_n) [*5])
    else $error("ack clock low phase too short");
  stop_drive_a: assert property (stop_w |-> ##[1:4] (!sda_oe_n && !scl_oe_n))
    else $error("stop request did not pull data low");
  irq_gate_a: assert property (ien_r == 2'b00 && $past(ien_r) == 2'b00 |-> !event_irq)
    else $error("irq raised with enables off");
  seen_clear_a: assert property (pready && !pwrite && paddr == IMASA_OFF_STAT && !en_r |-> prdata[1:0] == 2'b00)
    else $error("start or stop seen while disabled");
  cover property (ack_w);
  cover property (stop_w);
  cover property ($rose(event_irq));
endmodule
bind imasa_core imasa_core_sva imasa_core_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .scl_i, .sda_i, .scl_o, .sda_o, .scl_oe_n, .sda_oe_n, .event_irq);
`default_nettype wire

// ===== test/imasa_bus_model.sv
// Purpose: pulled-up two-wire bus with a slave and a rival master
// Assumes: released lines float high
// Notes: slave takes the first byte after a start and acks it
`timescale 1ns/1ps
`default_nettype none
module imasa_bus_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic pull_sda,
  input wire logic pull_scl,
  output logic scl_i,
  output logic sda_i,
  output logic [7:0] rx_byte,
  output logic [7:0] n_stops
);
  logic [3:0] nbits = 4'hE;
  logic ack_drv = 1'b0;
  initial rx_byte = 8'h00;
  initial n_stops = 8'h00;
  // wired-and with pull-ups, rival master pulls either line
  assign scl_i = scl_oe_n & ~pull_scl;
  assign sda_i = sda_oe_n & ~pull_sda & ~ack_drv;
  always @(negedge sda_i) begin
    if (scl_i) begin
      nbits = 4'hF;
      ack_drv = 1'b0;
    end
  end
  // each stop seen adds one to n_stops
  always @(posedge sda_i) begin
    if (scl_i) begin
      n_stops = n_stops + 8'h01;
    end
  end
  always @(posedge scl_i) begin
    if (nbits < 4'h8) begin
      rx_byte = {rx_byte[6:0], sda_i};
    end
  end
  always @(negedge scl_i) begin
    if (nbits != 4'hE) begin
      nbits = nbits + 4'h1;
    end
    ack_drv = (nbits == 4'h8);
  end
endmodule
`default_nettype wire

// ===== test/imasa_core_tb.sv
// Purpose: self-checking bench for imasa_core
// Assumes: bus model pulls both lines up
// Notes: reload drawn from 3 to 8
`timescale 1ns/1ps
`default_nettype none
module imasa_core_tb;
  import imasa_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, scl_i, sda_i, scl_o, sda_o, scl_oe_n, sda_oe_n, event_irq, v;
  logic pull_sda = 1'b0;
  logic pull_scl = 1'b0;
  logic [7:0] rx_byte, n_stops, d, n0;
  int bad_count = 0;
  int n_tests = 0;
  integer seed = 32'h3a77;
  initial forever #2.5 pclk = ~pclk;
  imasa_core imasa_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .scl_i, .sda_i, .scl_o, .sda_o, .scl_oe_n, .sda_oe_n, .event_irq);
  imasa_bus_model imasa_bus_model_i (.scl_oe_n, .sda_oe_n, .pull_sda, .pull_scl, .scl_i, .sda_i, .rx_byte,
    .n_stops);
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] x);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k == 20) begin
      chk("pready", 32'h1, 32'h0);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  task automatic waitf(input logic [31:0] m);
    int k;
    k = 0;
    do begin
      apb(1'b0, IMASA_OFF_FLAG, 32'h0);
      k++;
    end while ((rd & m) !== m && k < 400);
    chk("flag", m, rd & m);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(IMASA_OFF_RELOAD, 32'hFF, 32'h13, "reload");
    rchk(IMASA_OFF_STAT, 32'h3, 32'h0, "seen");
    apb(1'b1, 8'h18, 32'h1);
    chk("slverr", 32'h1, {31'h0, err});
    d = 8'h03 + 8'($unsigned($random(seed)) % 6);
    apb(1'b1, IMASA_OFF_RELOAD, {24'h0, d});
    apb(1'b1, IMASA_OFF_IEN, 32'h3);
    apb(1'b1, IMASA_OFF_CTRL, 32'h1);
    apb(1'b1, IMASA_OFF_CTRL, 32'h3);
    waitf(32'h1);
    chk("start", 32'h0, {30'h0, scl_oe_n, sda_oe_n});
    chk("irq", 32'h1, {31'h0, event_irq});
    chk("open drain", 32'h0, {30'h0, scl_o, sda_o});
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    $display("test start done");
    pull_sda <= 1'b1;
    apb(1'b1, IMASA_OFF_SHIFT, {24'h0, 8'h80 | 8'($random(seed))});
    waitf(32'h2);
    chk("released", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    rchk(IMASA_OFF_STAT, 32'h4, 32'h0, "full");
    pull_sda <= 1'b0;
    waitf(32'h1);
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    apb(1'b1, IMASA_OFF_CTRL, 32'h3);
    pull_sda <= 1'b1;
    waitf(32'h1);
    pull_sda <= 1'b0;
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    d = 8'($random(seed));
    apb(1'b1, IMASA_OFF_SHIFT, {24'h0, d});
    waitf(32'h1);
    chk("byte", {24'h0, d}, {24'h0, rx_byte});
    rchk(IMASA_OFF_STAT, 32'h8, 32'h0, "ackstat");
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    $display("test collision done");
    v = 1'($random(seed));
    apb(1'b1, IMASA_OFF_CTRL, {27'h0, v, 4'h9});
    apb(1'b1, IMASA_OFF_SHIFT, 32'h55);
    chk("ack", {31'h0, v}, {30'h0, scl_oe_n, sda_oe_n});
    waitf(32'h1);
    rchk(IMASA_OFF_FLAG, 32'h4, 32'h4, "clash ack");
    rchk(IMASA_OFF_CTRL, 32'h8, 32'h0, "ack req");
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    n0 = n_stops;
    apb(1'b1, IMASA_OFF_CTRL, 32'h5);
    apb(1'b1, IMASA_OFF_SHIFT, 32'hAA);
    waitf(32'h1);
    rchk(IMASA_OFF_FLAG, 32'h4, 32'h4, "clash stop");
    rchk(IMASA_OFF_STAT, 32'h22, 32'h22, "stop free");
    rchk(IMASA_OFF_CTRL, 32'h4, 32'h0, "stop req");
    chk("stops", {24'h0, n0 + 8'h01}, {24'h0, n_stops});
    chk("idle", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    apb(1'b1, IMASA_OFF_FLAG, 32'h7);
    $display("test ack stop done");
    pull_scl <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, IMASA_OFF_CTRL, 32'h3);
    waitf(32'h2);
    rchk(IMASA_OFF_CTRL, 32'h2, 32'h0, "start req");
    pull_scl <= 1'b0;
    rchk(IMASA_OFF_FLAG, 32'h2, 32'h2, "bcl held");
    apb(1'b1, IMASA_OFF_IEN, 32'h0);
    apb(1'b1, IMASA_OFF_CTRL, 32'h0);
    rchk(IMASA_OFF_STAT, 32'h3, 32'h0, "seen off");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(IMASA_OFF_RELOAD, 32'hFF, 32'h13, "reload again");
    $display("test reset done");
    results;
  end
  initial begin
    #100000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
